// ### rtl/bit_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser; first stage feeds only the second
module bit_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (en) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : bit_sync

// ### rtl/i2c_addr_direction.sv
`timescale 1ns/1ps
// Summary of operation
// (R1) seven bits after start form address
// (R2) each slave on bus has unique address
// (R3) slave compares received address with own address
// (R4) match keeps slave selected until start/stop; selected clears at stop or a non-matching address event, not at start
// (R5) no interrupt for foreign, non-extension bytes
// (R6) shift register write starts address send
// (R7) received address byte lands in shift register
// (R8) address sits in upper seven bits
// (R9) master sends one direction bit after address
// (R10) direction zero: master sends data
// (R11) direction one: slave sends data
// (R12) matching slave acks ninth clock, else releases
module i2c_addr_direction
  import i2c_addr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic own_addr_wr,
  input wire logic [ADDR_W-1:0] own_addr_in,
  input wire logic master_en,
  input wire logic shift_wr,
  input wire logic [BYTE_W-1:0] shift_wdata,
  output logic [BYTE_W-1:0] bus_shift_register,
  output logic bus_transfer_interrupt,
  output logic selected,
  output logic direction,
  output logic addr_byte
);
  // ---------------- system clock side ----------------
  logic [ADDR_W-1:0] own_address_register, next_own;
  logic [BYTE_W-1:0] tx_byte, next_tx_byte;
  logic [BYTE_W-1:0] next_shift;
  logic tx_tog, next_tx_tog;
  logic ev_seen, next_ev_seen;
  logic sda_prev, next_sda_prev;
  logic next_irq, next_selected, next_direction, next_addr_byte;
  slave_state_e st, next_st;
  logic scl_s, sda_s, ev_tog_s;
  logic ev_edge, stop_seen;
  logic [1:0] scl_hist, next_scl_hist;
  // link side state read here
  logic ev_tog;
  link_byte_s ev;

  // pins and the event toggle enter this domain through two flops
  bit_sync #(.W(3)) u_sys_sync (
    .clk(clk),
    .en(ce),
    .d({scl, sda_i, ev_tog}),
    .q({scl_s, sda_s, ev_tog_s})
  );

  assign ev_edge = ev_tog_s != ev_seen;
  // stop: data rises while the clock has stayed high for three samples;
  // the bus clock runs faster than clk, so a data change caught between
  // high samples of two different clock pulses must not count as stop
  assign stop_seen = scl_s & (&scl_hist) & sda_s & ~sda_prev; // [R4]

  // system side next values
  always_comb begin
    next_own = own_address_register;
    next_tx_byte = tx_byte;
    next_shift = bus_shift_register;
    next_tx_tog = tx_tog;
    next_ev_seen = ev_seen;
    next_sda_prev = sda_s;
    next_scl_hist = {scl_hist[0], scl_s};
    next_st = st;
    next_irq = 1'b0;
    next_addr_byte = addr_byte;
    next_direction = direction;
    if (own_addr_wr) begin
      next_own = own_addr_in;
    end
    if (shift_wr) begin
      next_shift = shift_wdata; // [R6]
      next_tx_byte = shift_wdata; // [R6]
      next_tx_tog = ~tx_tog; // [R6]
    end
    // a byte from the link wins the shift register over a same-cycle write; the write still arms tx_byte and tx_tog
    if (ev_edge) begin
      next_ev_seen = ev_tog_s;
      next_shift = ev.data; // [R7]
      next_irq = 1'b1; // [R5]
      next_addr_byte = ev.addr;
      if (ev.addr) begin
        next_direction = ev.data[0]; // [R9]
        if (!ev.match) begin
          next_st = ST_IDLE;
        end else if (ev.data[0] == DIR_SLAVE_SENDS) begin
          next_st = ST_SEL_TX; // [R11]
        end else begin
          next_st = ST_SEL_RX; // [R10]
        end
      end
    end
    if (stop_seen) begin
      next_st = ST_IDLE; // [R4]
    end
    next_selected = next_st != ST_IDLE; // [R4]
  end

  // system side registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      own_address_register <= OWN_ADDR_RST;
      tx_byte <= TX_BYTE_RST;
      bus_shift_register <= SHIFT_RST;
      tx_tog <= 1'b0;
      ev_seen <= 1'b0;
      sda_prev <= 1'b1;
      scl_hist <= 2'b00;
      st <= ST_IDLE;
      bus_transfer_interrupt <= 1'b0;
      selected <= 1'b0;
      direction <= DIR_MASTER_SENDS;
      addr_byte <= 1'b0;
    end else if (ce) begin
      own_address_register <= next_own;
      tx_byte <= next_tx_byte;
      bus_shift_register <= next_shift;
      tx_tog <= next_tx_tog;
      ev_seen <= next_ev_seen;
      sda_prev <= next_sda_prev;
      scl_hist <= next_scl_hist;
      st <= next_st;
      bus_transfer_interrupt <= next_irq;
      selected <= next_selected;
      direction <= next_direction;
      addr_byte <= next_addr_byte;
    end
  end

  // ---------------- link clock side ----------------
  logic lrst_n, lce, mst_s, tx_tog_s;
  logic [ADDR_W-1:0] own_s;
  logic [3:0] cnt, next_cnt;
  logic [ADDR_W-1:0] shreg, next_shreg;
  logic [BYTE_W-1:0] rx_byte;
  logic sda_r, next_sda_r;
  logic addr_phase, next_addr_phase;
  logic sel_link, next_sel_link;
  logic dir_link, next_dir_link;
  logic tx_go, next_tx_go;
  logic ack_due, next_ack_due;
  logic next_ev_tog;
  link_byte_s next_ev;
  logic match, ext, qualified;
  // falling edge group
  logic start_flag, next_start_flag;
  logic tx_on, next_tx_on;
  logic tx_mst, next_tx_mst;
  logic tx_seen, next_tx_seen;
  logic [BYTE_W-1:0] txb, next_txb;
  logic next_oe, start_det, tx_pend;

  // reset, enable and settings reach the link clock through two flops;
  // own address and tx byte are taken as static while a frame runs
  bit_sync #(.W(LINK_SYNC_W)) u_link_sync (
    .clk(scl),
    .en(1'b1),
    .d({nrst, ce, master_en, tx_tog, own_address_register}),
    .q({lrst_n, lce, mst_s, tx_tog_s, own_s})
  );

  assign rx_byte = {shreg, sda_i};
  assign match = addr_phase & (rx_byte[BYTE_W-1:1] == own_s); // [R3] [R8]
  assign ext = addr_phase & (rx_byte[BYTE_W-1:BYTE_W-5] == EXT_CODE);
  // foreign bytes raise nothing
  assign qualified = match | ext | (~addr_phase & sel_link) | tx_mst; // [R5]

  // rising edge: sample data, count bits, judge completed bytes
  always_comb begin
    next_cnt = cnt;
    next_shreg = shreg;
    next_sda_r = sda_r;
    next_addr_phase = addr_phase;
    next_sel_link = sel_link;
    next_dir_link = dir_link;
    next_tx_go = tx_go;
    next_ack_due = ack_due;
    next_ev_tog = ev_tog;
    next_ev = ev;
    if (lce) begin
      next_sda_r = sda_i;
      if (start_flag) begin
        next_cnt = CNT_FIRST; // [R1]
        next_shreg = {{(ADDR_W-1){1'b0}}, sda_i}; // [R1]
        next_addr_phase = 1'b1; // [R1]
        next_sel_link = 1'b0; // [R4]
        next_tx_go = 1'b0;
        next_ack_due = 1'b0;
      end else begin
        case (cnt)
          CNT_ACK_SLOT: begin
            next_cnt = CNT_RST;
            next_addr_phase = 1'b0;
            next_ack_due = 1'b0;
            // slave keeps sending while the master acks
            if (addr_phase) begin
              next_tx_go = sel_link & (dir_link == DIR_SLAVE_SENDS); // [R11]
            end else begin
              next_tx_go = tx_go & ~sda_i; // [R11]
            end
          end
          CNT_LAST_DATA: begin
            next_cnt = CNT_ACK_SLOT;
            if (addr_phase) begin
              next_sel_link = match; // [R3] [R4]
              next_dir_link = rx_byte[0]; // [R9]
            end
            next_ack_due = match | (~addr_phase & sel_link & (dir_link == DIR_MASTER_SENDS)); // [R12]
            if (qualified) begin
              next_ev_tog = ~ev_tog; // [R5]
              next_ev = '{data: rx_byte, addr: addr_phase, match: match, ext: ext};
            end
          end
          default: begin
            next_cnt = cnt + 4'h1;
            next_shreg = {shreg[ADDR_W-2:0], sda_i};
          end
        endcase
      end
    end
  end

  always_ff @(posedge scl) begin
    if (!lrst_n) begin
      cnt <= CNT_RST;
      shreg <= '0;
      sda_r <= 1'b1;
      addr_phase <= 1'b0;
      sel_link <= 1'b0;
      dir_link <= DIR_MASTER_SENDS;
      tx_go <= 1'b0;
      ack_due <= 1'b0;
      ev_tog <= 1'b0;
      ev <= '0;
    end else begin
      cnt <= next_cnt;
      shreg <= next_shreg;
      sda_r <= next_sda_r;
      addr_phase <= next_addr_phase;
      sel_link <= next_sel_link;
      dir_link <= next_dir_link;
      tx_go <= next_tx_go;
      ack_due <= next_ack_due;
      ev_tog <= next_ev_tog;
      ev <= next_ev;
    end
  end

  // start: data was high at the rising edge, low at the falling one
  assign start_det = sda_r & ~sda_i;
  assign tx_pend = tx_tog_s != tx_seen;

  // falling edge: drive the data line while the clock is low
  always_comb begin
    next_start_flag = start_flag;
    next_tx_on = tx_on;
    next_tx_mst = tx_mst;
    next_tx_seen = tx_seen;
    next_txb = txb;
    next_oe = sda_oe;
    if (lce) begin
      next_start_flag = start_det;
      if (start_det) begin
        next_tx_mst = mst_s & tx_pend; // [R6]
        next_tx_on = mst_s & tx_pend;
        next_oe = 1'b0;
        if (mst_s && tx_pend) begin
          next_tx_seen = tx_tog_s;
          next_oe = ~tx_byte[BYTE_W-1]; // [R6] [R8]
          next_txb = {tx_byte[BYTE_W-2:0], 1'b1};
        end
      end else begin
        case (cnt)
          CNT_ACK_SLOT: begin
            // a sender releases so the receiver can ack
            next_oe = ack_due & ~tx_on; // [R12]
          end
          CNT_RST: begin
            next_tx_mst = 1'b0;
            next_tx_on = tx_go;
            next_oe = 1'b0;
            if (tx_go) begin
              next_tx_seen = tx_tog_s;
              next_oe = ~tx_byte[BYTE_W-1]; // [R11]
              next_txb = {tx_byte[BYTE_W-2:0], 1'b1};
            end
          end
          default: begin
            next_oe = tx_on & ~txb[BYTE_W-1];
            next_txb = {txb[BYTE_W-2:0], 1'b1};
          end
        endcase
      end
    end
  end

  always_ff @(negedge scl) begin
    if (!lrst_n) begin
      start_flag <= 1'b0;
      tx_on <= 1'b0;
      tx_mst <= 1'b0;
      tx_seen <= 1'b0;
      txb <= TX_BYTE_RST;
      sda_oe <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      start_flag <= next_start_flag;
      tx_on <= next_tx_on;
      tx_mst <= next_tx_mst;
      tx_seen <= next_tx_seen;
      txb <= next_txb;
      sda_oe <= next_oe;
      sda_o <= 1'b0; // open drain: only ever pulls low
    end
  end

  // ---------------- checks ----------------
  addr_field_a: assert property (@(posedge scl) disable iff (!lrst_n) // [R1]
    (start_flag && lce) ##1 (!start_flag && lce)[*7] |=> cnt == CNT_ACK_SLOT)
    else $error("address byte not complete after seven more bits");

  addr_cmp_a: assert property (@(posedge scl) disable iff (!lrst_n) // [R3]
    (cnt == CNT_LAST_DATA && addr_phase && !start_flag && lce)
      |=> sel_link == ($past(rx_byte[BYTE_W-1:1]) == own_s))
    else $error("selection does not follow upper seven address bits");

  ack_drive_a: assert property (@(negedge scl) disable iff (!lrst_n) // [R12]
    (cnt == CNT_ACK_SLOT && !start_det && lce && !tx_on) |=> (sda_oe == $past(ack_due)))
    else $error("ninth clock ack does not follow address match");

  no_foreign_a: assert property (@(posedge scl) disable iff (!lrst_n) // [R5]
    (cnt == CNT_LAST_DATA && addr_phase && !start_flag && lce && !match && !ext && !tx_mst)
      |=> $stable(ev_tog))
    else $error("foreign address raised a byte event");

  irq_cause_a: assert property (@(posedge clk) disable iff (!nrst) // [R5]
    bus_transfer_interrupt |-> $past(ev_edge) && $past(ce))
    else $error("interrupt without a link byte");

  rx_store_a: assert property (@(posedge clk) disable iff (!nrst) // [R7]
    (ev_edge && ce) |=> bus_shift_register == $past(ev.data))
    else $error("received byte not in shift register");

  sel_keep_a: assert property (@(posedge clk) disable iff (!nrst) // [R4]
    (ce && (stop_seen || (ev_edge && ev.addr && !ev.match))) |=> !selected)
    else $error("slave still selected after stop or foreign address");

  dir_take_a: assert property (@(posedge clk) disable iff (!nrst) // [R9]
    (ev_edge && ev.addr && ev.match && ce && !stop_seen)
      |=> selected && direction == $past(ev.data[0]))
    else $error("direction bit not taken from address byte");

  tx_write_a: assert property (@(posedge clk) disable iff (!nrst) // [R6]
    (shift_wr && ce) |=> tx_byte == $past(shift_wdata) && tx_tog != $past(tx_tog))
    else $error("shift register write did not arm a send");

  slave_send_a: assert property (@(negedge scl) disable iff (!lrst_n) // [R11]
    (sda_oe && tx_on && !tx_mst) |-> sel_link && dir_link == DIR_SLAVE_SENDS)
    else $error("slave drives data without read direction");

  match_cov: cover property (@(posedge clk) disable iff (!nrst)
    ev_edge && ev.addr && ev.match);
  slave_tx_cov: cover property (@(negedge scl) disable iff (!lrst_n)
    tx_on && !tx_mst && sda_oe);
  master_addr_cov: cover property (@(negedge scl) disable iff (!lrst_n)
    start_det && mst_s && tx_pend);
endmodule : i2c_addr_direction

// ### rtl/i2c_addr_pkg.sv
package i2c_addr_pkg;
  localparam int ADDR_W = 7;
  localparam int BYTE_W = 8;
  localparam int LINK_SYNC_W = 11;
  // bit counter values inside one byte frame
  localparam logic [3:0] CNT_FIRST = 4'h1;
  localparam logic [3:0] CNT_LAST_DATA = 4'h7;
  localparam logic [3:0] CNT_ACK_SLOT = 4'h8;
  localparam logic [3:0] CNT_RST = 4'h0;
  // upper five bits of an extension code byte
  localparam logic [4:0] EXT_CODE = 5'h1e;
  // values after reset
  localparam logic [ADDR_W-1:0] OWN_ADDR_RST = 7'h00;
  localparam logic [BYTE_W-1:0] SHIFT_RST = 8'h00;
  localparam logic [BYTE_W-1:0] TX_BYTE_RST = 8'hff;
  // direction bit meaning
  localparam logic DIR_MASTER_SENDS = 1'b0;
  localparam logic DIR_SLAVE_SENDS = 1'b1;

  typedef enum {ST_IDLE, ST_SEL_RX, ST_SEL_TX} slave_state_e;

  // one byte handed from the link side to the system side
  typedef struct packed {
    logic [BYTE_W-1:0] data;
    logic addr;
    logic match;
    logic ext;
  } link_byte_s;
endpackage : i2c_addr_pkg

// ### sim/bus_master_model.sv
`timescale 1ns/1ps
// stand-in for the far-side master and the other slaves on the two wires
module bus_master_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // scl stands high between frames, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // free pulses with data released, so reset and settings can pass the link flops
  task automatic idle(input int n);
    repeat (n) begin
      #32 scl = 1'b0;
      #32 scl = 1'b1;
    end
  endtask : idle

  // two released pulses carry settings to the link flops and give the
  // start detector a rise with data high; then data falls while scl is high
  task automatic start;
    idle(2);
    #7 sda_low = 1'b1;
    #32 scl = 1'b0;
  endtask : start

  // data rises while scl is high; both levels held long enough for the
  // slower clk side to see scl high on several samples
  task automatic stop;
    #8 sda_low = 1'b1;
    #24 scl = 1'b1;
    #400 sda_low = 1'b0;
    #400;
  endtask : stop

  // data changes a little after scl falls (hold), sampled on the rising edge
  task automatic clk_bit(input logic b, output logic r);
    #8 sda_low = !b;
    #24 scl = 1'b1;
    r = sda;
    #32 scl = 1'b0;
  endtask : clk_bit

  // eight bits of address and direction or of data, msb first; ninth clock for the ack
  task automatic send_byte(input logic [7:0] d, input logic ack_in, output logic [7:0] r,
                           output logic ack);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], r[i]);
    end
    clk_bit(ack_in, ack);
  endtask : send_byte
endmodule : bus_master_model

// ### sim/tb_i2c_address_direction_logic.sv
`timescale 1ns/1ps
module tb_i2c_address_direction_logic import i2c_addr_pkg::*; ;
  // the stand-in slaves never use this address
  localparam logic [ADDR_W-1:0] own_val = 7'h5a;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic scl, m_low, sda_o, sda_oe, selected, direction, addr_byte, irq;
  logic own_addr_wr = 1'b0;
  logic master_en = 1'b0;
  logic shift_wr = 1'b0;
  logic [BYTE_W-1:0] shift_wdata = 8'h00;
  logic [BYTE_W-1:0] bsr;
  logic [7:0] irq_cnt = 8'h00;
  int num_errors = 0;
  int compares = 0;
  // open drain: any party pulling wins, otherwise the pull-up
  wire logic sda_line = !(m_low || (sda_oe && !sda_o));

  always #50 clk = ~clk;

  i2c_addr_direction dut (.clk(clk), .nrst(nrst), .ce(1'b1), .scl(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .own_addr_wr(own_addr_wr), .own_addr_in(own_val),
    .master_en(master_en), .shift_wr(shift_wr), .shift_wdata(shift_wdata),
    .bus_shift_register(bsr), .bus_transfer_interrupt(irq), .selected(selected),
    .direction(direction), .addr_byte(addr_byte));
  bus_master_model m (.scl(scl), .sda_low(m_low), .sda(sda_line));

  // counting pulses avoids guessing the exact sync latency
  always @(posedge clk) begin
    if (irq === 1'b1) irq_cnt <= irq_cnt + 8'h01;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one byte from the master, then time for the clk side to settle
  task automatic frame(input logic [7:0] d, output logic ack);
    logic [7:0] r;
    m.send_byte(d, 1'b1, r, ack);
    repeat (6) @(negedge clk);
  endtask : frame

  task automatic write_byte(input logic [7:0] d);
    @(negedge clk);
    shift_wdata = d;
    shift_wr = 1'b1;
    @(negedge clk);
    shift_wr = 1'b0;
  endtask : write_byte

  task automatic t_write;
    logic ack;
    logic [7:0] base;
    base = irq_cnt;
    m.start();
    frame({own_val, DIR_MASTER_SENDS}, ack);
    chk(ack, 8'h00);
    chk(irq_cnt - base, 8'h01);
    chk(bsr, {own_val, DIR_MASTER_SENDS});
    chk(selected, 8'h01);
    chk(direction, 8'h00);
    chk(addr_byte, 8'h01);
    frame(8'h3c, ack);
    chk(ack, 8'h00);
    chk(bsr, 8'h3c);
    chk(addr_byte, 8'h00);
    m.stop();
    repeat (6) @(negedge clk);
    chk(selected, 8'h00);
    $display("test write done");
  endtask : t_write

  task automatic t_foreign;
    logic ack;
    logic [7:0] base;
    base = irq_cnt;
    m.start();
    frame({7'h11, DIR_MASTER_SENDS}, ack);
    chk(ack, 8'h01);
    chk(irq_cnt - base, 8'h00);
    chk(bsr, 8'h3c);
    chk(selected, 8'h00);
    m.stop();
    base = irq_cnt;
    m.start();
    frame({EXT_CODE, 2'b00, 1'b0}, ack);
    chk(ack, 8'h01);
    chk(irq_cnt - base, 8'h01);
    m.stop();
    $display("test foreign done");
  endtask : t_foreign

  task automatic t_read;
    logic ack;
    logic [7:0] r;
    write_byte(8'ha5);
    m.start();
    frame({own_val, DIR_SLAVE_SENDS}, ack);
    chk(ack, 8'h00);
    chk(direction, 8'h01);
    m.send_byte(8'hff, 1'b1, r, ack);
    chk(r, 8'ha5);
    m.stop();
    repeat (6) @(negedge clk);
    $display("test read done");
  endtask : t_read

  task automatic t_master;
    logic ack;
    logic [7:0] r;
    logic [7:0] base;
    master_en = 1'b1;
    write_byte(8'hc6);
    chk(bsr, 8'hc6);
    base = irq_cnt;
    m.start();
    m.send_byte(8'hff, 1'b0, r, ack);
    chk(r, 8'hc6);
    m.stop();
    repeat (6) @(negedge clk);
    chk(irq_cnt - base, 8'h01);
    master_en = 1'b0;
    $display("test master done");
  endtask : t_master

  task automatic summarize;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // whole run is about fifteen microseconds
  initial begin
    #200000;
    num_errors++;
    summarize();
  end

  // scl must toggle while reset is held so the link flops clear too
  initial begin
    fork
      repeat (10) @(negedge clk);
      m.idle(6);
    join
    nrst = 1'b1;
    own_addr_wr = 1'b1;
    @(negedge clk);
    own_addr_wr = 1'b0;
    m.idle(3);
    t_write();
    t_foreign();
    t_read();
    t_master();
    summarize();
  end
endmodule : tb_i2c_address_direction_logic
